// ===== core/ostc_decode.sv
// fuse decoder: maps source-select and start-up fuses to a configuration
// assumes fuses are stable while sampled; purely combinational
`timescale 1ns/1ns
`default_nettype none
module ostc_decode (
  input  wire logic [3:0]         src_fuses,
  input  wire logic [1:0]         sut_fuses,
  output var  ostc_pkg::ostc_cfg_t cfg
);
  // table lookups from the fuse fields
  always_comb begin
    cfg          = '0;
    cfg.band     = src_fuses[3:1];
    cfg.src      = ostc_pkg::OSTC_SRC_BAD;
    cfg.invalid  = 1'b1;
    cfg.rt_cyc   = '0;  // no real-time wait, so refused codes reach halt quickly
    cfg.wake_cyc = ostc_pkg::WAKE_LONG;
    if (src_fuses[3]) begin
      cfg.src     = ostc_pkg::OSTC_SRC_XTAL;
      cfg.invalid = 1'b0;
      case ({src_fuses[0], sut_fuses})
        3'h0, 3'h1:       cfg.wake_cyc = ostc_pkg::WAKE_SHORT;
        3'h2, 3'h3, 3'h4: cfg.wake_cyc = ostc_pkg::WAKE_MID;
        default:          cfg.wake_cyc = ostc_pkg::WAKE_LONG;
      endcase
      case ({src_fuses[0], sut_fuses})
        3'h0, 3'h3, 3'h6: cfg.rt_cyc = ostc_pkg::WDT_4MS;
        3'h1, 3'h4, 3'h7: cfg.rt_cyc = ostc_pkg::WDT_65MS;
        default:          cfg.rt_cyc = '0;
      endcase
    end else if (src_fuses == ostc_pkg::SRC_RC4_LO || src_fuses == ostc_pkg::SRC_RC4_HI ||
                 src_fuses == ostc_pkg::SRC_RC8_LO || src_fuses == ostc_pkg::SRC_RC8_HI) begin
      cfg.src      = src_fuses[2] ? ostc_pkg::OSTC_SRC_RC8 : ostc_pkg::OSTC_SRC_RC4;
      cfg.wake_cyc = ostc_pkg::WAKE_RC;
      cfg.invalid  = (sut_fuses == ostc_pkg::SUT_RESV);
      case (sut_fuses)
        2'h0:    cfg.rt_cyc = '0;
        2'h1:    cfg.rt_cyc = ostc_pkg::WDT_4MS;
        2'h2:    cfg.rt_cyc = ostc_pkg::WDT_65MS;
        default: cfg.rt_cyc = '0;                         // reserved, halts anyway
      endcase
    end
    // other codes (external, 128k, reserved) stay invalid here
  end
endmodule : ostc_decode
`default_nettype wire

// ===== core/ostc_pkg.sv
// package for the oscillator select, start-up and trim block
// assumes a 100 MHz system clock and active-low fuse bits
package ostc_pkg;
  // avalon word addresses (byte address = 4 * index)
  localparam logic [3:0] ADDR_TRIM    = 4'h0;  // rc_oscillator_trim
  localparam logic [3:0] ADDR_CONFIG  = 4'h1;  // decoded fuse view, read only
  localparam logic [3:0] ADDR_STATUS  = 4'h2;  // sequencer state
  localparam logic [3:0] ADDR_CONTROL = 4'h3;  // wake request, write only pulse
  // fuse codes, 1 = unprogrammed
  localparam logic [3:0] SRC_RC4_LO  = 4'h2;
  localparam logic [3:0] SRC_RC4_HI  = 4'h3;
  localparam logic [3:0] SRC_RC8_LO  = 4'h4;
  localparam logic [3:0] SRC_RC8_HI  = 4'h5;
  localparam logic [3:0] DEF_SRC     = 4'h4;   // shipped source select
  localparam logic [1:0] DEF_SUT     = 2'h2;   // shipped start-up code
  localparam logic [1:0] SUT_RESV    = 2'h3;
  // crystal bands on source bits 3..1
  localparam logic [2:0] BAND_0P4    = 3'h4;
  localparam logic [2:0] BAND_0P9    = 3'h5;
  localparam logic [2:0] BAND_3P0    = 3'h6;
  localparam logic [2:0] BAND_8P0    = 3'h7;
  // oscillator cycle counts
  localparam logic [14:0] WAKE_SHORT = 15'h0102; // 258
  localparam logic [14:0] WAKE_MID   = 15'h0400; // 1K
  localparam logic [14:0] WAKE_LONG  = 15'h4000; // 16K
  localparam logic [14:0] WAKE_RC    = 15'h0006; // 6
  localparam logic [14:0] RST_CYC    = 15'h000E; // 14
  // real-time delay in watchdog oscillator cycles
  localparam logic [13:0] WDT_4MS    = 14'h0200; // 512
  localparam logic [13:0] WDT_65MS   = 14'h2000; // 8192
  localparam logic [6:0]  TRIM_MAX   = 7'h7F;
  // trim percentage of nominal, min/max at 0x00, 0x3F, 0x7F
  localparam int TRIM_MIN_PCT_LO = 50;
  localparam int TRIM_MAX_PCT_HI = 200;

  typedef enum logic [1:0] {
    OSTC_SRC_XTAL = 2'h0, OSTC_SRC_RC4 = 2'h1, OSTC_SRC_RC8 = 2'h2, OSTC_SRC_BAD = 2'h3
  } ostc_src_t;

  // gray-coded sequencer states
  typedef enum logic [2:0] {
    OSTC_ST_RTDLY = 3'b000, OSTC_ST_CKDLY = 3'b001, OSTC_ST_RUN = 3'b011,
    OSTC_ST_WAKE  = 3'b010, OSTC_ST_HALT  = 3'b110
  } ostc_st_t;

  // decoded configuration
  typedef struct packed {
    ostc_src_t   src;
    logic [2:0]  band;
    logic        invalid;
    logic [14:0] wake_cyc;
    logic [13:0] rt_cyc;
  } ostc_cfg_t;

  // avalon slave request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } ostc_av_req_t;
endpackage : ostc_pkg

// ===== core/ostc_top.sv
// oscillator select, start-up sequencer and rc trim register
// assumes an avalon-mm master on clk; wdt_osc_tick and osc_tick are pins
// from other oscillators and pass two flip-flops before use
`timescale 1ns/1ns
`default_nettype none
// Function
// - upper source bits pick crystal band
// - wake wait 258/1K/16K by fuse code
// - crystal settings give listed reset delays
// - resonator settings give listed reset delays
// - codes 0010-0101 select rc 4/8 MHz
// - rc: 6 wake cycles, sut delays
// - default is rc 8 MHz, sut 10
// - reset loads calibration byte into trim
// - watchdog oscillator times reset delay
// - 7-bit trim tunes frequency monotonically
// - trim range 50-200 percent of nominal
// - delay 512 or 8K watchdog cycles
// - fuse bits active low, 0 programmed
// - codes 1xxx select crystal amplifier
// - wake wait counted in source cycles
module ostc_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [3:0]  clock_source_select_fuses, // raw, 0 = programmed
  input  wire logic [1:0]  startup_time_fuses,
  input  wire logic        divide_by_eight_fuse,
  input  wire logic        fuses_blank,               // unprogrammed part
  input  wire logic [7:0]  calibration_byte,          // factory value
  input  wire logic        wdt_osc_tick,              // watchdog osc, async
  input  wire logic        osc_tick,                  // selected source, async
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [2:0]       crystal_band_select,
  output logic             rc_select,
  output logic             rc_8mhz,
  output logic [6:0]       trim_value,
  output logic             prescale_div8,
  output logic             config_invalid,
  output logic             cpu_run
);
  // all state except the output flops in one struct
  typedef struct packed {
    logic [3:0]           src;       // latched fuses
    logic [1:0]           sut;
    logic                 div8;
    logic [7:0]           trim;
    ostc_pkg::ostc_st_t   st;
    logic [14:0]          ck_cnt;
    logic [13:0]          wd_cnt;
    logic [2:0]           wd_sync;   // two sync stages plus edge history
    logic [2:0]           ck_sync;
    logic                 ack;       // answer phase of avalon access
    logic [31:0]          rdata;
    logic                 wake_req;
    logic                 sleep_req;
    logic                 woke;      // wake seen, source edges now counted
  } ostc_state_t;

  ostc_state_t          s;
  ostc_state_t          next_s;
  ostc_pkg::ostc_cfg_t  cfg;
  logic [3:0]           eff_src;     // fuses, or shipped default if blank
  logic [1:0]           eff_sut;
  logic                 wd_edge;
  logic                 ck_edge;

  // blank parts behave as shipped
  assign eff_src = fuses_blank ? ostc_pkg::DEF_SRC : clock_source_select_fuses;
  assign eff_sut = fuses_blank ? ostc_pkg::DEF_SUT : startup_time_fuses;

  // decode works on the latched copy so runtime fuse noise cannot matter
  ostc_decode u_dec (
    .src_fuses (s.src),
    .sut_fuses (s.sut),
    .cfg       (cfg)
  );

  // edges taken only from second and third stages, never the first
  assign wd_edge = s.wd_sync[1] & ~s.wd_sync[2];
  assign ck_edge = s.ck_sync[1] & ~s.ck_sync[2];

  // register read mux, shared by the read path
  function automatic logic [31:0] rd_mux(input logic [3:0] a, input ostc_state_t q,
                                         input ostc_pkg::ostc_cfg_t c);
    logic [31:0] r;
    r = '0;
    case (a)
      ostc_pkg::ADDR_TRIM:   r = {24'h000000, q.trim};
      ostc_pkg::ADDR_CONFIG: r = {21'h000000, q.div8, q.sut, q.src, 1'b0, c.invalid, c.src};
      ostc_pkg::ADDR_STATUS: r = {29'h00000000, q.st};
      default:               r = '0;   // unmapped reads as zero
    endcase
    return r;
  endfunction : rd_mux

  // next-state logic
  always_comb begin
    next_s          = s;
    next_s.wd_sync  = {s.wd_sync[1:0], wdt_osc_tick};
    next_s.ck_sync  = {s.ck_sync[1:0], osc_tick};
    next_s.wake_req = 1'b0;
    next_s.sleep_req = 1'b0;
    // one wait state: answer on second cycle of each request
    next_s.ack      = (avs_read | avs_write) & ~s.ack;
    if ((avs_read | avs_write) & ~s.ack) begin
      if (avs_read) begin
        next_s.rdata = rd_mux(avs_address, s, cfg);
      end
    end
    // writes commit on the answer edge, where the master sees waitrequest low
    if (avs_write & s.ack) begin
      if (avs_address == ostc_pkg::ADDR_TRIM) begin
        next_s.trim = avs_writedata[7:0];   // bit 7 stored, only 6..0 tune
      end
      if (avs_address == ostc_pkg::ADDR_CONTROL) begin
        next_s.wake_req  = avs_writedata[0];
        next_s.sleep_req = avs_writedata[1];
      end
    end
    // start-up sequencer
    case (s.st)
      ostc_pkg::OSTC_ST_RTDLY: begin
        // real-time part counted on watchdog oscillator
        if (s.wd_cnt >= cfg.rt_cyc) begin
          next_s.st     = ostc_pkg::OSTC_ST_CKDLY;
          next_s.ck_cnt = '0;
        end else if (wd_edge) begin
          next_s.wd_cnt = s.wd_cnt + 14'h0001;
        end
      end
      ostc_pkg::OSTC_ST_CKDLY: begin
        // fixed 14 oscillator cycles after reset
        if (cfg.invalid) begin
          next_s.st = ostc_pkg::OSTC_ST_HALT;
        end else if (s.ck_cnt >= ostc_pkg::RST_CYC) begin
          next_s.st = ostc_pkg::OSTC_ST_RUN;
        end else if (ck_edge) begin
          next_s.ck_cnt = s.ck_cnt + 15'h0001;
        end
      end
      ostc_pkg::OSTC_ST_RUN: begin
        if (s.sleep_req) begin
          next_s.st = ostc_pkg::OSTC_ST_WAKE;
          next_s.ck_cnt = '0;
          next_s.woke = 1'b0;
        end
      end
      ostc_pkg::OSTC_ST_WAKE: begin
        // power-down: wait for wake, then count source cycles
        if (s.ck_cnt >= cfg.wake_cyc) begin
          next_s.st = ostc_pkg::OSTC_ST_RUN;
          next_s.woke = 1'b0;
        end else begin
          // the wake strobe itself is no source edge, so it is not counted
          if (s.wake_req) begin
            next_s.woke = 1'b1;
          end
          if (s.woke & ck_edge) begin
            next_s.ck_cnt = s.ck_cnt + 15'h0001;
          end
        end
      end
      ostc_pkg::OSTC_ST_HALT: begin
        next_s.st = ostc_pkg::OSTC_ST_HALT;     // invalid fuses hold the core
      end
      default: next_s.st = ostc_pkg::OSTC_ST_HALT;
    endcase
  end

  // register stage; reset latches fuses and calibration
  always_ff @(posedge clk) begin
    if (srst) begin
      s        <= '0;
      s.src    <= eff_src;
      s.sut    <= eff_sut;
      s.div8   <= ~divide_by_eight_fuse; // programmed when 0
      s.trim   <= calibration_byte;
      s.st     <= ostc_pkg::OSTC_ST_RTDLY;
    end else begin
      s <= next_s;
    end
  end

  // output flops fed from next_s and cfg; only prescale_div8 comes straight from state
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata        <= '0;
      avs_waitrequest     <= 1'b1;
      crystal_band_select <= '0;
      rc_select           <= 1'b0;
      rc_8mhz             <= 1'b0;
      trim_value          <= '0;
      prescale_div8       <= 1'b0;
      config_invalid      <= 1'b0;
      cpu_run             <= 1'b0;
    end else begin
      avs_readdata        <= next_s.rdata;
      avs_waitrequest     <= ~next_s.ack;
      crystal_band_select <= cfg.band;
      rc_select           <= (cfg.src == ostc_pkg::OSTC_SRC_RC4) |
                             (cfg.src == ostc_pkg::OSTC_SRC_RC8);
      rc_8mhz             <= (cfg.src == ostc_pkg::OSTC_SRC_RC8);
      trim_value          <= next_s.trim[6:0];
      prescale_div8       <= s.div8;
      config_invalid      <= cfg.invalid;
      cpu_run             <= (next_s.st == ostc_pkg::OSTC_ST_RUN);
    end
  end

  // assertions
  property p_trim_load;
    @(posedge clk) $fell(srst) |=> trim_value == $past(calibration_byte[6:0], 2);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded at reset");

  property p_trim_write;
    @(posedge clk) disable iff (srst)
      (avs_write && !s.ack && avs_address == ostc_pkg::ADDR_TRIM) |=> ##1
        trim_value == $past(avs_writedata[6:0], 2);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  property p_band;
    @(posedge clk) disable iff (srst)
      !$past(srst) |-> crystal_band_select == $past(s.src[3:1]);
  endproperty
  a_band: assert property (p_band) else $error("band mismatch");

  property p_rc_sel;
    @(posedge clk) disable iff (srst)
      (!$past(srst) && s.src == ostc_pkg::SRC_RC8_LO) |=> rc_select && rc_8mhz;
  endproperty
  a_rc_sel: assert property (p_rc_sel) else $error("rc 8 MHz not chosen");

  property p_rc_wake;
    @(posedge clk) disable iff (srst)
      (cfg.src == ostc_pkg::OSTC_SRC_RC8) |-> cfg.wake_cyc == ostc_pkg::WAKE_RC;
  endproperty
  a_rc_wake: assert property (p_rc_wake) else $error("rc wake count wrong");

  property p_xtal_long;
    @(posedge clk) disable iff (srst)
      (s.src[3] && s.src[0] && s.sut != 2'h0) |-> cfg.wake_cyc == ostc_pkg::WAKE_LONG;
  endproperty
  a_xtal_long: assert property (p_xtal_long) else $error("crystal wait not 16K");

  property p_rt_wait;
    @(posedge clk) disable iff (srst)
      (s.st == ostc_pkg::OSTC_ST_RTDLY && s.wd_cnt < cfg.rt_cyc) |=>
        s.st == ostc_pkg::OSTC_ST_RTDLY;
  endproperty
  a_rt_wait: assert property (p_rt_wait) else $error("reset delay cut short");

  property p_wd_step;
    @(posedge clk) disable iff (srst)
      (s.st == ostc_pkg::OSTC_ST_RTDLY && !wd_edge) |=> $stable(s.wd_cnt);
  endproperty
  a_wd_step: assert property (p_wd_step) else $error("delay not on watchdog osc");

  property p_invalid_halt;
    @(posedge clk) disable iff (srst)
      (s.st == ostc_pkg::OSTC_ST_CKDLY && cfg.invalid) |=> ##1 !cpu_run;
  endproperty
  a_invalid_halt: assert property (p_invalid_halt) else $error("invalid fuses ran");

  property p_wait_ans;
    @(posedge clk) disable iff (srst)
      (avs_read && avs_waitrequest) |-> ##[0:2] !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("avalon answer late");

  c_run:   cover property (@(posedge clk) disable iff (srst) $rose(cpu_run));
  c_wake:  cover property (@(posedge clk) disable iff (srst)
                           s.st == ostc_pkg::OSTC_ST_WAKE ##1 s.st == ostc_pkg::OSTC_ST_RUN);
  c_halt:  cover property (@(posedge clk) s.st == ostc_pkg::OSTC_ST_HALT);
  c_twr:   cover property (@(posedge clk) disable iff (srst)
                           avs_write && avs_address == ostc_pkg::ADDR_TRIM);
endmodule : ostc_top
`default_nettype wire

// ===== dv/oscillator_select_startup_trim_tb_top.sv
// self-checking bench for the oscillator select, start-up and trim block
// assumes ostc_top with fuse pins, avalon-mm slave and two tick inputs
`timescale 1ns/1ns
`default_nettype none
module oscillator_select_startup_trim_tb_top;
  // one table row: fuse setting and what it should give
  typedef struct packed {
    logic [3:0]          src;
    logic [1:0]          sut;
    logic                blank;
    logic                inv;
    ostc_pkg::ostc_src_t kind;
    logic [15:0]         rt;  // watchdog edges before the 14 osc edges
    logic [15:0]         wk;  // wake edges, 0 = wake not exercised
  } ostc_tb_row_t;

  logic        clk;
  logic        srst;
  logic [3:0]  fuses;
  logic [1:0]  sut;
  logic        div8;
  logic        blank;
  logic [7:0]  cal;
  logic        wdt_tick;
  logic        osc_tick;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  band;
  logic        rc_select;
  logic        rc_8mhz;
  logic [6:0]  trim_value;
  logic        prescale_div8;
  logic        config_invalid;
  logic        cpu_run;
  int          errors;
  int          checks_done;

  // long counts kept to 8192 and 16384 edges once each to bound run time
  localparam ostc_tb_row_t ROWS [12] = '{
    '{4'hF, 2'h0, 1'b1, 1'b0, ostc_pkg::OSTC_SRC_RC8,  16'd8192, 16'd6},
    '{4'h8, 2'h0, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_XTAL, 16'd512,  16'd258},
    '{4'hB, 2'h1, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_XTAL, 16'd0,    16'd16384},
    '{4'hD, 2'h2, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_XTAL, 16'd512,  16'd0},
    '{4'hE, 2'h2, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_XTAL, 16'd0,    16'd1024},
    '{4'hA, 2'h3, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_XTAL, 16'd512,  16'd0},
    '{4'h2, 2'h3, 1'b0, 1'b1, ostc_pkg::OSTC_SRC_BAD,  16'd0,    16'd0},
    '{4'h0, 2'h0, 1'b0, 1'b1, ostc_pkg::OSTC_SRC_BAD,  16'd0,    16'd0},
    '{4'h6, 2'h0, 1'b0, 1'b1, ostc_pkg::OSTC_SRC_BAD,  16'd0,    16'd0},
    '{4'h7, 2'h1, 1'b0, 1'b1, ostc_pkg::OSTC_SRC_BAD,  16'd0,    16'd0},
    '{4'h3, 2'h1, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_RC4,  16'd512,  16'd6},
    '{4'h5, 2'h0, 1'b0, 1'b0, ostc_pkg::OSTC_SRC_RC8,  16'd0,    16'd0}
  };
  // steps of at most 0x21 on bits 6..0, no flash writes while trimmed high
  localparam logic [7:0] TRIM_VALS [4] = '{8'h3E, 8'h5E, 8'h7F, 8'hDF};

  ostc_top ostc_top_i (
    .clk                       (clk),
    .srst                      (srst),
    .clock_source_select_fuses (fuses),
    .startup_time_fuses        (sut),
    .divide_by_eight_fuse      (div8),
    .fuses_blank               (blank),
    .calibration_byte          (cal),
    .wdt_osc_tick              (wdt_tick),
    .osc_tick                  (osc_tick),
    .avs_address               (avs_address),
    .avs_read                  (avs_read),
    .avs_write                 (avs_write),
    .avs_writedata             (avs_writedata),
    .avs_readdata              (avs_readdata),
    .avs_waitrequest           (avs_waitrequest),
    .crystal_band_select       (band),
    .rc_select                 (rc_select),
    .rc_8mhz                   (rc_8mhz),
    .trim_value                (trim_value),
    .prescale_div8             (prescale_div8),
    .config_invalid            (config_invalid),
    .cpu_run                   (cpu_run)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // compare seen against expected, count both
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk(32'h1, 32'h0);  // slave never answered
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // let an edge pass so a following call does not re-raise in this step
    @(posedge clk);
  endtask : bus

  // one rising edge on both oscillators; two clocks per period
  task automatic pulse();
    wdt_tick <= 1'b1;
    osc_tick <= 1'b1;
    @(posedge clk);
    wdt_tick <= 1'b0;
    osc_tick <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // edges given until cpu_run; slack of four covers the synchroniser
  task automatic run_after(input int exp);
    int k;
    k = 0;
    while (cpu_run !== 1'b1 && k < 20000) begin
      pulse();
      k++;
    end
    chk(32'(k >= exp && k <= exp + 4), 32'h1);
  endtask : run_after

  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // watchdog: the long rows need about 49k cycles
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("watchdog ran out");
    close_out();
  end

  // main sequence
  initial begin
    ostc_tb_row_t r;
    logic [3:0]  es;
    logic [1:0]  eu;
    logic [31:0] rd;
    logic [31:0] c0;
    clk = 1'b0;
    srst = 1'b1;
    fuses = 4'h0;
    sut = 2'h0;
    div8 = 1'b1;
    blank = 1'b0;
    cal = 8'h00;
    wdt_tick = 1'b0;
    osc_tick = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    errors = 0;
    checks_done = 0;
    // table rows: reset with the row's fuses, then check and run
    for (int i = 0; i < 12; i++) begin
      r  = ROWS[i];
      es = r.blank ? ostc_pkg::DEF_SRC : r.src;
      eu = r.blank ? ostc_pkg::DEF_SUT : r.sut;
      @(posedge clk);
      srst  <= 1'b1;
      fuses <= r.src;
      sut   <= r.sut;
      blank <= r.blank;
      div8  <= i[0];
      cal   <= 8'hA5 ^ 8'(i * 17);
      repeat (12) @(posedge clk);
      chk(32'({avs_waitrequest, cpu_run}), 32'h2);  // waitrequest high in reset
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      // flip the pins; the latched view must not follow
      fuses <= ~r.src;
      sut   <= ~r.sut;
      blank <= ~r.blank;
      chk(32'(config_invalid), 32'(r.inv));
      chk(32'(prescale_div8), 32'(!i[0]));
      chk(32'(trim_value), 32'(cal[6:0]));
      bus(1'b0, ostc_pkg::ADDR_CONFIG, 32'h0, rd);
      chk(32'({rd[9:4], rd[2]}), 32'({eu, es, r.inv}));
      if (r.inv) begin
        // refused configuration never reaches run
        repeat (40) pulse();
        chk(32'(cpu_run), 32'h0);
      end else begin
        chk(32'(band), 32'(es[3:1]));
        chk(32'({rc_select, rc_8mhz}), 32'({r.kind != ostc_pkg::OSTC_SRC_XTAL,
            r.kind == ostc_pkg::OSTC_SRC_RC8}));
        chk(32'(rd[1:0]), 32'(r.kind));
        run_after(int'(r.rt) + int'(ostc_pkg::RST_CYC));
        if (r.wk != 16'd0) begin
          // power-down, then wake on the latched wake count
          bus(1'b1, ostc_pkg::ADDR_CONTROL, 32'h2, rd);
          repeat (2) @(posedge clk);
          chk(32'(cpu_run), 32'h0);
          bus(1'b1, ostc_pkg::ADDR_CONTROL, 32'h1, rd);
          run_after(int'(r.wk));
        end
      end
      $display("test row %0d done", i);
    end
    // trim register write and read back, bit 7 stored only
    foreach (TRIM_VALS[j]) begin
      bus(1'b1, ostc_pkg::ADDR_TRIM, 32'(TRIM_VALS[j]), rd);
      bus(1'b0, ostc_pkg::ADDR_TRIM, 32'h0, rd);
      chk(rd & 32'hFF, 32'(TRIM_VALS[j]));
      chk(32'(trim_value), 32'(TRIM_VALS[j][6:0]));
    end
    $display("test trim done");
    // read-only and unmapped places ignore writes
    bus(1'b0, ostc_pkg::ADDR_CONFIG, 32'h0, c0);
    bus(1'b1, ostc_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, rd);
    bus(1'b0, ostc_pkg::ADDR_CONFIG, 32'h0, rd);
    chk(rd, c0);
    bus(1'b1, 4'h9, 32'hFFFF_FFFF, rd);
    bus(1'b0, 4'h9, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test refused writes done");
    // second reset in mid-run reloads the calibration byte over the trim
    cal  <= 8'h3C;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(trim_value), 32'h3C);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : oscillator_select_startup_trim_tb_top
`default_nettype wire
